// >>> hw/pstl_pkg.sv
// Constants, carriers and state types of the phase-selective trip logic
package pstl_pkg;

  // Timing: core clock period and the millisecond time base
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_TIME_NS = 1_000_000;
  localparam int unsigned TICK_CYC = TICK_TIME_NS / CLK_PERIOD_NS;

  // Millisecond settings: limits and reset values
  localparam logic [15:0] TIME_MIN_MS = 16'd50;
  localparam logic [15:0] TIME_MAX_MS = 16'd60000;
  localparam logic [15:0] PULSE_DEF_MS = 16'd150;
  localparam logic [15:0] EVOL_DEF_MS = 16'd1000;

  // Register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_PULSE = 8'h04;
  localparam logic [7:0] ADDR_EVOL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;

  // Field positions and widths
  localparam int unsigned MODE_W = 2;
  localparam int unsigned MS_W = 16;
  localparam int unsigned EV_W = 5;
  localparam int unsigned STAT_EVOL_BIT = 5;
  localparam int unsigned STAT_MODE_LSB = 8;

  // AHB-Lite transfer type bit that marks NONSEQ or SEQ
  localparam int unsigned HTRANS_ACT_BIT = 1;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_TRIP3 = 2'h1,
    MODE_TRIP13 = 2'h2
  } pstl_mode_e;

  // Requests from the protection functions
  typedef struct packed {
    logic blk;
    logic force_all_phases_in;
    logic single_phase_trip_request;
    logic three_phase_trip_signal;
    logic phase_three_trip_request;
    logic phase_two_trip_request;
    logic phase_one_trip_request;
  } pstl_req_s;

  // Trip outputs, same layout as the status and event bits
  typedef struct packed {
    logic general_trip_out;
    logic three_phase_trip_signal;
    logic phase_three_trip_out;
    logic phase_two_trip_out;
    logic phase_one_trip_out;
  } pstl_trip_s;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [MS_W-1:0] pulse_ms;
    logic [MS_W-1:0] evol_ms;
    logic [2:0][MS_W-1:0] ph_cnt;
    logic [MS_W-1:0] tp_cnt;
    logic [MS_W-1:0] ev_cnt;
    logic [2:0] mask;
    pstl_trip_s out;
    logic [EV_W-1:0] ist;
    logic [EV_W-1:0] imsk;
    logic irq;
    logic dp_wr;
    logic [7:0] dp_adr;
    logic [31:0] rdata;
    logic rdy;
  } pstl_st_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } pstl_tick_s;

endpackage

// >>> hw/pstl_tick.sv
// Millisecond tick divider of the phase-selective trip logic
`timescale 1ns/1ps
module pstl_tick #(
  parameter int unsigned CYCLES = pstl_pkg::TICK_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic tick
);

  pstl_pkg::pstl_tick_s q;
  pstl_pkg::pstl_tick_s d;

  // One-cycle pulse every CYCLES clocks
  always_comb begin
    d = q;
    if (q.cnt >= CYCLES - 32'h0000_0001) begin
      d.cnt = 32'h0000_0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h0000_0001;
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  tick_gap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (q.tick && CYCLES > 1) |=> !q.tick) else $error("tick pulses back to back");

endmodule

// >>> hw/pstl_trip.sv
// Phase-selective trip decision logic with AHB-Lite registers
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module pstl_trip #(
  parameter int unsigned TICK_CYCLES = pstl_pkg::TICK_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire pstl_pkg::pstl_req_s trip_req,
  output pstl_pkg::pstl_trip_s trip_out,
  output logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // Settings outside the legal range are pulled to the nearest limit
  function automatic logic [15:0] clamp_ms(input logic [31:0] v);
    logic [15:0] r;
    if (v < {16'h0000, pstl_pkg::TIME_MIN_MS}) begin
      r = pstl_pkg::TIME_MIN_MS;
    end else if (v > {16'h0000, pstl_pkg::TIME_MAX_MS}) begin
      r = pstl_pkg::TIME_MAX_MS;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

  function automatic logic [1:0] ones3(input logic [2:0] v);
    return {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  // Millisecond counter step: reload wins, else count down on a tick
  function automatic logic [15:0] ms_step(
    input logic load,
    input logic [15:0] val,
    input logic tk,
    input logic [15:0] cnt
  );
    logic [15:0] r;
    r = cnt;
    if (load) begin
      r = val;
    end else if (tk && cnt != 16'h0000) begin
      r = cnt - 16'h0001;
    end
    return r;
  endfunction

  pstl_pkg::pstl_st_s q;
  pstl_pkg::pstl_st_s d;
  logic tick;
  logic en;
  logic any_req;
  logic need3;
  logic evol_new;
  logic [2:0] ph_req;
  logic [2:0] raw_ph;
  logic raw3;
  logic [2:0] hold;
  logic hold3;
  logic gen;
  logic [4:0] ev_set;
  logic [4:0] ev_clr;
  logic ap_hit;

  pstl_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(tick)
  );

  always_comb begin
    d = q;
    ph_req = {trip_req.phase_three_trip_request,
              trip_req.phase_two_trip_request,
              trip_req.phase_one_trip_request};
    // Illegal mode codes block tripping like off, but the evolving window runs down instead of clearing
    en = (q.mode == pstl_pkg::MODE_TRIP3 || q.mode == pstl_pkg::MODE_TRIP13)
         && !trip_req.blk;
    any_req = trip_req.single_phase_trip_request || trip_req.three_phase_trip_signal || (|ph_req);
    evol_new = (q.ev_cnt != 16'h0000) && (|(ph_req & ~q.mask));
    need3 = (q.mode == pstl_pkg::MODE_TRIP3)
            || trip_req.three_phase_trip_signal
            || trip_req.force_all_phases_in
            || ones3(ph_req) >= 2'h2
            || evol_new
            || (trip_req.single_phase_trip_request && ph_req == 3'h0);
    // Unstretched trip, pure logic of inputs and state
    raw3 = en && any_req && need3;
    raw_ph = 3'h0;
    if (en && any_req) begin
      raw_ph = need3 ? 3'h7 : ph_req;
    end
    // Stretching: a request reloads the full pulse, so one cycle is enough
    for (int i = 0; i < 3; i++) begin
      d.ph_cnt[i] = en ? ms_step(raw_ph[i], q.pulse_ms, tick, q.ph_cnt[i]) : 16'h0000;
      hold[i] = d.ph_cnt[i] != 16'h0000;
    end
    d.tp_cnt = en ? ms_step(raw3, q.pulse_ms, tick, q.tp_cnt) : 16'h0000;
    hold3 = d.tp_cnt != 16'h0000;
    gen = hold3 || (|hold);
    d.out = pstl_pkg::pstl_trip_s'({gen, hold3, hold});
    // Evolving window runs through the trip and for the set time after it
    d.ev_cnt = ms_step(gen, q.evol_ms, tick, q.ev_cnt);
    if (q.mode == pstl_pkg::MODE_OFF) begin
      d.ev_cnt = 16'h0000;
    end
    if (q.ev_cnt != 16'h0000 || gen) begin
      d.mask = q.mask | hold;
    end else begin
      d.mask = 3'h0;
    end
    // Events: rising edge of each output; a set in the clear cycle wins
    ev_set = d.out & ~q.out;
    ev_clr = 5'h00;
    // Data phase of a write
    if (q.dp_wr) begin
      unique case (q.dp_adr)
        pstl_pkg::ADDR_CFG: d.mode = hwdata[1:0];
        pstl_pkg::ADDR_PULSE: d.pulse_ms = clamp_ms(hwdata);
        pstl_pkg::ADDR_EVOL: d.evol_ms = clamp_ms(hwdata);
        pstl_pkg::ADDR_ISTAT: ev_clr = hwdata[4:0];
        pstl_pkg::ADDR_IMASK: d.imsk = hwdata[4:0];
        default: ev_clr = 5'h00;
      endcase
    end
    d.ist = (q.ist & ~ev_clr) | ev_set;
    d.irq = |(d.ist & d.imsk);
    // Address phase: reads are answered from a register in the data phase
    d.dp_wr = 1'b0;
    d.rdata = 32'h0000_0000;
    ap_hit = hsel && htrans[pstl_pkg::HTRANS_ACT_BIT] && hready;
    if (ap_hit) begin
      d.dp_adr = haddr[7:0];
      d.dp_wr = hwrite && (haddr[31:8] == 24'h00_0000);
      if (!hwrite && haddr[31:8] == 24'h00_0000) begin
        unique case (haddr[7:0])
          pstl_pkg::ADDR_CFG: d.rdata = {30'h0000_0000, q.mode};
          pstl_pkg::ADDR_PULSE: d.rdata = {16'h0000, q.pulse_ms};
          pstl_pkg::ADDR_EVOL: d.rdata = {16'h0000, q.evol_ms};
          pstl_pkg::ADDR_STAT: d.rdata = {22'h00_0000, q.mode, 2'h0, q.ev_cnt != 16'h0000, q.out};
          pstl_pkg::ADDR_ISTAT: d.rdata = {27'h000_0000, q.ist};
          pstl_pkg::ADDR_IMASK: d.rdata = {27'h000_0000, q.imsk};
          default: d.rdata = 32'h0000_0000;
        endcase
      end
    end
    d.rdy = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q <= '0;
      q.mode <= pstl_pkg::MODE_OFF;
      q.pulse_ms <= pstl_pkg::PULSE_DEF_MS;
      q.evol_ms <= pstl_pkg::EVOL_DEF_MS;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign trip_out = q.out;
  assign irq = q.irq;
  assign hreadyout = q.rdy;
  assign hrdata = q.rdata;
  assign hresp = 1'b0;

  // Helper for the pulse length check
  logic [31:0] hi_cnt;
  logic [31:0] pulse_lim;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hi_cnt <= 32'h0000_0000;
    end else if (q.out.phase_one_trip_out) begin
      hi_cnt <= hi_cnt + 32'h0000_0001;
    end else begin
      hi_cnt <= 32'h0000_0000;
    end
  end
  assign pulse_lim = 32'((32'(q.pulse_ms) - 32'h0000_0001) * TICK_CYCLES);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_en;
    (q.mode == pstl_pkg::MODE_TRIP3 || q.mode == pstl_pkg::MODE_TRIP13) && !trip_req.blk;
  endsequence

  sequence s_two_ph;
    ones3(ph_req) == 2'h2;
  endsequence

  sequence s_all_out;
    q.out.phase_one_trip_out && q.out.phase_two_trip_out && q.out.phase_three_trip_out;
  endsequence

  reset_default_a: assert property (@(posedge core_clk) disable iff (1'b0)
    !nrst |=> (q.mode == pstl_pkg::MODE_OFF && q.pulse_ms == pstl_pkg::PULSE_DEF_MS
               && q.evol_ms == pstl_pkg::EVOL_DEF_MS)) else $error("bad reset settings");

  off_quiet_a: assert property (q.mode == pstl_pkg::MODE_OFF |=> q.out == 5'h00)
    else $error("trip output while mode off");

  block_quiet_a: assert property (trip_req.blk |=> q.out == 5'h00)
    else $error("trip output while blocked");

  min_pulse_a: assert property ($fell(q.out.phase_one_trip_out) && $past(en) |-> $past(hi_cnt) >= pulse_lim)
    else $error("trip pulse shorter than minimum");

  short_req_a: assert property (s_en ##0 trip_req.phase_one_trip_request ##1 s_en [*8]
    |-> q.out.phase_one_trip_out) else $error("short request not stretched");

  two_phase_a: assert property (s_en ##0 s_two_ph |=> s_all_out)
    else $error("third phase not tripped");

  three_req_a: assert property (s_en ##0 trip_req.three_phase_trip_signal
    |=> s_all_out ##0 q.out.three_phase_trip_signal) else $error("three-phase request ignored");

  evolving_a: assert property (s_en ##0 evol_new |=> s_all_out ##0 q.out.three_phase_trip_signal)
    else $error("evolving fault not tripped three-phase");

  force_a: assert property (s_en ##0 trip_req.force_all_phases_in ##0 (|ph_req) |=> s_all_out)
    else $error("forced three-phase trip missing");

  general_a: assert property (q.out.general_trip_out == (|q.out[3:0]))
    else $error("general trip mismatch");

  trip3_mode_a: assert property (q.mode == pstl_pkg::MODE_TRIP3 && !trip_req.blk && any_req
    |=> s_all_out ##0 q.out.three_phase_trip_signal) else $error("three-phase mode tripped one phase");

  single_a: assert property (q.mode == pstl_pkg::MODE_TRIP13 && !trip_req.blk && ph_req == 3'h2
    && !need3 && q.tp_cnt == 16'h0000 && q.ph_cnt[0] == 16'h0000 && q.ph_cnt[2] == 16'h0000
    |=> q.out.phase_two_trip_out && !q.out.phase_one_trip_out && !q.out.three_phase_trip_signal)
    else $error("lone phase not tripped alone");

  raw_follow_a: assert property (s_en ##0 (raw_ph != 3'h0) |=> (q.out[2:0] & $past(raw_ph)) == $past(raw_ph))
    else $error("combinational trip not applied");

  irq_level_a: assert property ($rose(q.out.general_trip_out) && q.imsk[4] |=> q.irq)
    else $error("interrupt missing on trip");

endmodule

// >>> sim/pstl_prot_model.sv
// Protection-function model that issues trip requests of a chosen length
`timescale 1ns/1ps
module pstl_prot_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic fire,
  input wire pstl_pkg::pstl_req_s cmd,
  input wire logic [7:0] len,
  output pstl_pkg::pstl_req_s trip_req
);
  logic [7:0] left_q;
  pstl_pkg::pstl_req_s held_q;
  // Phase one, two and three requests stand beside the single and three-phase requests
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      left_q <= 8'h00;
      held_q <= '0;
    end else if (fire) begin
      left_q <= len;
      held_q <= cmd;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // Requests are levels that rest inactive between commands
  assign trip_req = (left_q != 8'h00) ? held_q : '0;
endmodule

// >>> sim/test_pstl_trip.sv
// Self-checking bench of the phase-selective trip logic
`timescale 1ns/1ps
module test_pstl_trip;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic fire = 1'b0;
  pstl_pkg::pstl_req_s cmd = '0;
  pstl_pkg::pstl_req_s trip_req;
  pstl_pkg::pstl_trip_s trip_out;
  logic irq, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [6:0] cmds [4] = '{7'h03, 7'h09, 7'h21, 7'h41};
  logic [4:0] exps [4] = '{5'h1F, 5'h1F, 5'h1F, 5'h00};
  int error_cnt = 0;
  int comparisons = 0;

  always #20 core_clk = ~core_clk;

  // Small divider so one millisecond is four clocks and pulses stay short
  pstl_trip #(.TICK_CYCLES(4)) u_pstl_trip (.core_clk(core_clk), .nrst(nrst), .trip_req(trip_req),
    .trip_out(trip_out), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));
  pstl_prot_model u_pstl_prot_model (.core_clk(core_clk), .nrst(nrst), .fire(fire), .cmd(cmd),
    .len(8'h01), .trip_req(trip_req));

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check("hrdata", q, e);
    check("hresp", 32'(hresp), 32'h0000_0000);
  endtask

  // One-cycle request from the model, trip outputs looked at one clock after it
  task automatic shoot(input logic [6:0] c, input logic [4:0] e);
    @(posedge core_clk);
    fire <= 1'b1;
    cmd <= c;
    @(posedge core_clk);
    fire <= 1'b0;
    @(posedge core_clk);
    #1;
    check("trip_out", 32'(trip_out), 32'(e));
  endtask

  // Outlasts the pulse and the evolving window that follows it
  task automatic settle();
    repeat (480) @(posedge core_clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rd(pstl_pkg::ADDR_CFG, 32'h0000_0000);
    rd(pstl_pkg::ADDR_PULSE, 32'h0000_0096);
    rd(pstl_pkg::ADDR_EVOL, 32'h0000_03E8);
    rd(pstl_pkg::ADDR_IMASK, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    $display("test reset_values done");
    shoot(7'h01, 5'h00);
    settle();
    $display("test mode_off done");
    wr(pstl_pkg::ADDR_PULSE, 32'h0000_000A);
    rd(pstl_pkg::ADDR_PULSE, 32'h0000_0032);
    wr(pstl_pkg::ADDR_EVOL, 32'h0000_EA61);
    rd(pstl_pkg::ADDR_EVOL, 32'h0000_EA60);
    wr(pstl_pkg::ADDR_EVOL, 32'h0000_0032);
    wr(pstl_pkg::ADDR_IMASK, 32'h0000_0001);
    wr(pstl_pkg::ADDR_CFG, 32'h0000_0002);
    shoot(7'h01, 5'h11);
    repeat (195) @(posedge core_clk);
    #1;
    check("trip_out", 32'(trip_out), 32'h0000_0011);
    check("irq", 32'(irq), 32'h0000_0001);
    repeat (8) @(posedge core_clk);
    #1;
    check("trip_out", 32'(trip_out), 32'h0000_0000);
    shoot(7'h02, 5'h1F);
    settle();
    $display("test pulse_evolving done");
    rd(pstl_pkg::ADDR_ISTAT, 32'h0000_001F);
    wr(pstl_pkg::ADDR_ISTAT, 32'h0000_0001);
    rd(pstl_pkg::ADDR_ISTAT, 32'h0000_001E);
    check("irq", 32'(irq), 32'h0000_0000);
    wr(pstl_pkg::ADDR_ISTAT, 32'h0000_001F);
    $display("test interrupt done");
    for (int i = 0; i < 4; i++) begin
      shoot(cmds[i], exps[i]);
      settle();
    end
    $display("test widening done");
    wr(pstl_pkg::ADDR_CFG, 32'h0000_0001);
    shoot(7'h01, 5'h1F);
    repeat (4) @(posedge core_clk);
    #1;
    check("irq", 32'(irq), 32'h0000_0001);
    rd(pstl_pkg::ADDR_STAT, 32'h0000_013F);
    wr(pstl_pkg::ADDR_IMASK, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    #1;
    check("irq", 32'(irq), 32'h0000_0000);
    $display("test three_phase_mode done");
    print_verdict();
  end
endmodule
